// ==== core/fcd_consts.vh ====
// Constants for the function capability descriptor bank.
// Assumes byte-wide configuration ROM reads from logic on the same clock.
`ifndef FCD_CONSTS_VH
`define FCD_CONSTS_VH

// Data width codes
`define FCD_DW_NONE 8'h00
`define FCD_DW_D08O 8'h81
`define FCD_DW_D08EO 8'h82
`define FCD_DW_D16 8'h83
`define FCD_DW_D32 8'h84
`define FCD_DW_MD32 8'h85

// Address modifier positions
`define FCD_AM_CFG_SPACE 6'h2F
`define FCD_AM_XAM_6U 6'h20
`define FCD_AM_XAM_3U 6'h21

// Decoder mask word fields
`define FCD_MW_MASK_LSB 8
`define FCD_MW_RSVD_HI 7
`define FCD_MW_RSVD_LO 4
`define FCD_MW_FIXED_BASE 3
`define FCD_MW_DYN_SIZE 2
`define FCD_MW_EXTRA_DEC 1
`define FCD_MW_UPPER_FOLLOWS 0

// Byte layout of one function slot, multi-byte fields most significant byte first
`define FCD_SLOT_BITS 6
`define FCD_OFS_DW 6'h00
`define FCD_OFS_AM 6'h01
`define FCD_OFS_XAM 6'h09
`define FCD_OFS_MW 6'h29
`define FCD_OFS_UMW 6'h2D
`define FCD_OFS_END 6'h31
`define FCD_UNMAPPED 8'h00

`endif

// ==== core/fcd_slot.v ====
// One function's descriptor set, cleaned to a legal form.
// Assumes the raw contents arrive as constants from the top's parameters.
`default_nettype none
`include "fcd_consts.vh"

module fcd_slot (
   input wire [7:0] raw_width,
   input wire [63:0] raw_am,
   input wire [255:0] raw_xam,
   input wire [31:0] raw_mask,
   input wire [31:0] raw_upper,
   output reg [7:0] width,
   output reg [63:0] am,
   output wire [255:0] xam,
   output reg [31:0] mask,
   output reg [31:0] upper,
   output reg bad
);
   // Keeps the leading run of ones, clears all bits after the first zero
   function [31:0] fcd_prefix;
      input [31:0] v;
      integer i;
      reg run;
      begin
         run = 1'b1;
         fcd_prefix = 32'h0000_0000;
         for (i = 31; i >= 0; i = i - 1) begin
            run = run & v[i];
            fcd_prefix[i] = run;
         end
      end
   endfunction

   reg [31:0] lower_m;
   reg upper_full;

   assign xam = raw_xam;

   always @* begin
      // Data width varies per function, as do the other descriptor fields; unknown codes read as none
      case (raw_width)
         `FCD_DW_NONE, `FCD_DW_D08O, `FCD_DW_D08EO,
         `FCD_DW_D16, `FCD_DW_D32, `FCD_DW_MD32: width = raw_width;
         default: width = `FCD_DW_NONE;
      endcase
      am = raw_am;
      am[`FCD_AM_CFG_SPACE] = 1'b0;
      // A function may not claim both forms; 6U wins
      if (raw_am[`FCD_AM_XAM_6U] && raw_am[`FCD_AM_XAM_3U]) begin
         am[`FCD_AM_XAM_3U] = 1'b0;
      end
      upper = fcd_prefix(raw_upper);
      upper_full = &upper;
      lower_m = fcd_prefix(raw_mask);
      // With a wide decoder, low mask bits are only legal below a full upper word
      if (raw_mask[`FCD_MW_UPPER_FOLLOWS] && !upper_full) begin
         lower_m = 32'h0000_0000;
      end
      mask = {lower_m[31:`FCD_MW_MASK_LSB], 8'h00};
      mask[`FCD_MW_RSVD_HI:`FCD_MW_RSVD_LO] = 4'h0;
      mask[`FCD_MW_FIXED_BASE] = raw_mask[`FCD_MW_FIXED_BASE];
      mask[`FCD_MW_DYN_SIZE] = raw_mask[`FCD_MW_DYN_SIZE];
      mask[`FCD_MW_EXTRA_DEC] = raw_mask[`FCD_MW_EXTRA_DEC];
      mask[`FCD_MW_UPPER_FOLLOWS] = raw_mask[`FCD_MW_UPPER_FOLLOWS];
      if (!raw_mask[`FCD_MW_UPPER_FOLLOWS]) begin
         upper = 32'h0000_0000;
      end
      // Extended codes without the 6U or 3U carrier bit are unusable
      bad = (width != raw_width) || (am != raw_am)
         || ((|raw_xam) && !am[`FCD_AM_XAM_6U] && !am[`FCD_AM_XAM_3U])
         || (mask[31:`FCD_MW_MASK_LSB] != raw_mask[31:`FCD_MW_MASK_LSB]
            && !raw_mask[`FCD_MW_DYN_SIZE])
         || (raw_mask[`FCD_MW_RSVD_HI:`FCD_MW_RSVD_LO] != 4'h0);
   end
endmodule
`default_nettype wire

// ==== core/fcd_byte_mux.v ====
// Picks one byte of a function slot by its offset.
// Assumes the slot fields are already cleaned; combinational only.
`default_nettype none
`include "fcd_consts.vh"

module fcd_byte_mux (
   input wire [`FCD_SLOT_BITS-1:0] ofs,
   input wire [7:0] width,
   input wire [63:0] am,
   input wire [255:0] xam,
   input wire [31:0] mask,
   input wire [31:0] upper,
   output reg [7:0] data
);
   reg [5:0] k;

   always @* begin
      k = 6'h00;
      data = `FCD_UNMAPPED;
      if (ofs == `FCD_OFS_DW) begin
         data = width;
      end else if (ofs < `FCD_OFS_XAM) begin
         k = ofs - `FCD_OFS_AM;
         data = am[(7 - k[2:0]) * 8 +: 8];
      end else if (ofs < `FCD_OFS_MW) begin
         k = ofs - `FCD_OFS_XAM;
         data = xam[(31 - k[4:0]) * 8 +: 8];
      end else if (ofs < `FCD_OFS_UMW) begin
         k = ofs - `FCD_OFS_MW;
         data = mask[(3 - k[1:0]) * 8 +: 8];
      end else if (ofs < `FCD_OFS_END) begin
         k = ofs - `FCD_OFS_UMW;
         data = upper[(3 - k[1:0]) * 8 +: 8];
      end
   end
endmodule
`default_nettype wire

// ==== core/fcd_bank.v ====
// Capability descriptor bank: up to eight functions, byte-wide reads.
// Assumes the reading logic runs on clk; writes are accepted and dropped.
`default_nettype none
`include "fcd_consts.vh"

module fcd_bank #(
   parameter NUM_FUNC = 8,
   parameter [8*NUM_FUNC-1:0] WIDTH_INIT = {NUM_FUNC{`FCD_DW_NONE}},
   parameter [64*NUM_FUNC-1:0] AM_INIT = {NUM_FUNC{64'h0}},
   parameter [256*NUM_FUNC-1:0] XAM_INIT = {NUM_FUNC{256'h0}},
   parameter [32*NUM_FUNC-1:0] MASK_INIT = {NUM_FUNC{32'h0}},
   parameter [32*NUM_FUNC-1:0] UPPER_INIT = {NUM_FUNC{32'h0}}
) (
   input wire clk,
   input wire resetn,
   input wire rd_en,
   input wire wr_en,
   input wire [8:0] addr,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output reg wr_ignored,
   output reg cfg_error
);
   localparam FSEL = 3;

   wire [7:0] slot_byte [0:NUM_FUNC-1];
   wire [NUM_FUNC-1:0] slot_bad;
   wire [FSEL-1:0] func = addr[`FCD_SLOT_BITS+FSEL-1:`FCD_SLOT_BITS];
   wire [`FCD_SLOT_BITS-1:0] ofs = addr[`FCD_SLOT_BITS-1:0];
   reg [7:0] next_rd_data;

   genvar g;
   generate
      for (g = 0; g < NUM_FUNC; g = g + 1) begin : gen_func
         wire [7:0] w;
         wire [63:0] a;
         wire [255:0] x;
         wire [31:0] m;
         wire [31:0] u;
         // Maximal decode width is set per function by the MASK_INIT and UPPER_INIT parameters
         fcd_slot u_slot (
            .raw_width(WIDTH_INIT[8*g +: 8]),
            .raw_am(AM_INIT[64*g +: 64]),
            .raw_xam(XAM_INIT[256*g +: 256]),
            .raw_mask(MASK_INIT[32*g +: 32]),
            .raw_upper(UPPER_INIT[32*g +: 32]),
            .width(w),
            .am(a),
            .xam(x),
            .mask(m),
            .upper(u),
            .bad(slot_bad[g])
         );
         fcd_byte_mux u_mux (
            .ofs(ofs),
            .width(w),
            .am(a),
            .xam(x),
            .mask(m),
            .upper(u),
            .data(slot_byte[g])
         );
      end
   endgenerate

   always @* begin
      next_rd_data = `FCD_UNMAPPED;
      if (func < NUM_FUNC) begin
         next_rd_data = slot_byte[func];
      end
   end

   // Content is parameter driven, so a write has nothing it could disturb
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         wr_ignored <= 1'b0;
         cfg_error <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= next_rd_data;
         end
         wr_ignored <= wr_en & (|wr_data | ~(|wr_data));
         cfg_error <= |slot_bad;
      end
   end
endmodule
`default_nettype wire

// ==== sim/fcd_assertions.sv ====
// Port checks for the descriptor bank.
// Assumes a single clk domain and the bank's byte slot layout.
`default_nettype none
module fcd_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [8:0] addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic wr_ignored
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_read_answer: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   a_valid_quiet: assert property (!rd_en |=> !rd_valid)
      else $error("valid without read");
   a_write_answer: assert property (wr_en |=> wr_ignored)
      else $error("write not acknowledged");
   a_write_quiet: assert property (!wr_en |=> !wr_ignored)
      else $error("spurious write ack");
   a_data_holds: assert property (!rd_en |=> $stable(rd_data))
      else $error("read data moved");
   a_width_legal: assert property (rd_en && addr[5:0] == 6'h00 |=>
      rd_data inside {8'h00, [8'h81:8'h85]}) else $error("bad width code");
   a_cfg_space_off: assert property (rd_en && addr[5:0] == 6'h03 |=> !rd_data[7])
      else $error("config space modifier advertised");
   a_one_xam_form: assert property (rd_en && addr[5:0] == 6'h04 |=> rd_data[1:0] != 2'h3)
      else $error("both extended forms");
   a_flags_reserved: assert property (rd_en && addr[5:0] == 6'h2C |=> rd_data[7:4] == 4'h0)
      else $error("reserved flags set");
endmodule
bind fcd_bank fcd_checker u_fcd_checker (.clk(clk), .resetn(resetn), .rd_en(rd_en),
   .wr_en(wr_en), .addr(addr), .rd_data(rd_data), .rd_valid(rd_valid), .wr_ignored(wr_ignored));
`default_nettype wire

// ==== sim/fcd_reader.sv ====
// Configuration master model: one queued operation per clock.
// Op -1 stalls; bit 9 write, bits 8:0 address, bits 17:10 data.
`default_nettype none
module fcd_reader (
   input wire logic clk,
   output logic rd_en,
   output logic wr_en,
   output logic [8:0] addr,
   output logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int q[$];
   int op;
   initial begin
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = 9'h000;
      wr_data = 8'h00;
   end
   always @(posedge clk) begin
      op = (q.size() > 0) ? q.pop_front() : -1;
      rd_en <= op >= 0 && !op[9];
      wr_en <= op >= 0 && op[9];
      // Idle bus shows toggling junk: the last address inverted, then back to the last address on the next idle clock
      addr <= (op < 0) ? ~addr : op[8:0];
      wr_data <= (op < 0) ? ~wr_data : op[17:10];
   end
endmodule
`default_nettype wire

// ==== sim/fcd_bank_test.sv ====
// Bench for the descriptor bank: scans, random traffic, rescan.
// Assumes the reader model and the bound checker.
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module fcd_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NF = 6;
   localparam [47:0] W = {8'h00, 8'h84, 8'h90, 8'h83, 8'h84, 8'h84};
   localparam [383:0] AM = {64'h0, 64'h1_0000_0000, 64'h8000_0000_0F00, 64'h0,
      64'hF00, 64'hF00};
   localparam [1535:0] XM = {256'h0, 256'h4, 1024'h0};
   localparam [191:0] MW = {32'hFFFFFF08, 32'hFF000001, 32'hFFF00000, 32'hFFFFFF04,
      32'hFFFE0000, 32'hFFFE0002};
   localparam [191:0] UP = {32'h0, 32'hFFFFFFFF, 128'h0};
   logic clk, resetn, rd_en, wr_en, rd_valid, wr_ignored, cfg_error;
   logic [8:0] addr;
   logic [7:0] wr_data, rd_data;
   logic [7:0] eq[$];
   int n_fail, tests_run, r;
   fcd_reader u_reader (.clk(clk), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
      .wr_data(wr_data));
   fcd_bank #(.NUM_FUNC(NF), .WIDTH_INIT(W), .AM_INIT(AM), .XAM_INIT(XM),
      .MASK_INIT(MW), .UPPER_INIT(UP)) u_fcd_bank (.clk(clk), .resetn(resetn),
      .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
      .rd_valid(rd_valid), .wr_ignored(wr_ignored), .cfg_error(cfg_error));
   function automatic logic [7:0] ex(int a);
      int f, o;
      logic [63:0] am;
      logic [31:0] m;
      logic [7:0] w;
      f = a / 64;
      o = a % 64;
      if (f >= NF || o >= 8'h31) return 8'h00;
      w = W[8*f+:8];
      am = AM[64*f+:64];
      am[47] = 1'b0;
      m = MW[32*f+:32];
      if (o == 0) return (w == 8'h00 || (w >= 8'h81 && w <= 8'h85)) ? w : 8'h00;
      if (o < 9) return am[8*(8-o)+:8];
      if (o < 41) return XM[256*f+8*(40-o)+:8];
      if (o < 45) return m[8*(44-o)+:8];
      return m[0] ? UP[32*f+8*(48-o)+:8] : 8'h00;
   endfunction
   task complete_run;
      $display("%0d checks, %0d failures", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always #2 clk = ~clk;
   always @(negedge clk) if (resetn) begin
      `CHK(rd_valid, eq.size() > 0)
      if (eq.size() > 0) `CHK(rd_data, eq.pop_front())
      if (rd_en) eq.push_back(ex(addr));
   end
   initial begin
      #20000;
      n_fail++;
      complete_run;
   end
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      r = $urandom(32'h22940958);
      repeat (12) @(posedge clk);
      `CHK(rd_data, 8'h00)
      resetn <= 1'b1;
      for (int a = 0; a < 512; a++) u_reader.q.push_back(a);
      // Random reads and dropped writes with stalls, then a full rescan
      repeat (300) begin
         r = $urandom;
         u_reader.q.push_back(r[20:19] == 2'h0 ? -1 : int'(r[17:0]));
      end
      for (int a = 0; a < 512; a++) u_reader.q.push_back(a);
      while (u_reader.q.size() > 0) @(posedge clk);
      repeat (4) @(posedge clk);
      `CHK(cfg_error, 1'b1)
      complete_run;
   end
endmodule
`default_nettype wire
